// File: rn_ring_node.sv
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps

// Behaviour
// - older word bits 0-15 enable nodes 0-15
// - older word bits 16-19 give sync node
// - older word bits 20-23 give master number
// - slave answers only its configured master number
// - bank word bits 8-23 enable nodes 0-15
// - bank word bits 0-7 ignored
// - bank word bits 24-27 give sync node
// - bank word bits 28-31 give master number
// - bank words writable only after unlock key
// - check window counted in interrupt periods; zero disables
// - errors above limit in window shut down
// - too few sync packets in window shut down
// - four output, four input registers per node
// - role decides command versus feedback direction
// - register 0 carries 24 bits, others 16
// - servo registers follow standard command/feedback usage
// - older element: write output, read input
// - older element: reg0 upper 24 bus bits, others upper 16
// - full-word view is 256 times element value
// - newer outputs read back separately from inputs
// - newer element: reg0 upper 24, others upper 16
// - master sends each cycle; slave answers immediately
// - eight-bit address must match to communicate: master number in bits 7-4, an enabled node in bits 3-0
module rn_ring_node (
  input  wire logic           i_sys_clk,
  input  wire logic           i_reset_n,
  input  wire logic           i_hsel,
  input  wire logic [31:0]    i_haddr,
  input  wire logic [1:0]     i_htrans,
  input  wire logic           i_hwrite,
  input  wire logic [2:0]     i_hsize,
  input  wire logic [31:0]    i_hwdata,
  input  wire logic           i_hready,
  output logic                o_hreadyout,
  output logic                o_hresp,
  output logic [31:0]         o_hrdata,
  input  wire logic           i_ring_cycle,
  input  wire logic           i_rti,
  input  wire logic           i_rx_valid,
  input  wire logic [7:0]     i_rx_addr,
  input  wire rn_pkg::rn_pkt_t i_rx_data,
  input  wire logic           i_rx_err,
  output logic                o_tx_valid,
  input  wire logic           i_tx_ready,
  output logic [7:0]          o_tx_addr,
  output rn_pkg::rn_pkt_t     o_tx_data,
  output logic                o_ring_shutdown
);
  import rn_pkg::*;

  typedef struct packed {
    logic [1:0]         ctrl;
    logic [23:0]        old_en;
    logic [31:0]        wp_key;
    logic [31:0]        a_en;
    logic [31:0]        b_en;
    logic [15:0]        win_len;
    logic [15:0]        err_lim;
    logic [15:0]        req_sync;
    logic [127:0][23:0] out_mem;
    logic [127:0][23:0] in_mem;
    rn_tx_state_e       tx_state;
    logic [4:0]         scan;
    logic               tx_valid;
    logic [7:0]         tx_addr;
    rn_pkt_t            tx_data;
  } rn_node_s;

  rn_node_s         st;
  rn_node_s         next_st;
  logic             newer;
  logic             slave;
  logic [1:0][15:0] nodes;
  logic [1:0][3:0]  sync_node;
  logic [1:0][3:0]  mnum;
  logic [1:0]       rx_hit;
  logic             rx_bank;
  logic [3:0]       rx_node;
  logic             rx_sync;
  logic             tx_free;
  logic             shutdown;
  logic             chk_active;
  logic             clear_shut;
  logic [15:0]      err_cnt;
  logic [15:0]      sync_cnt;
  logic [3:0]       region;
  logic [5:0]       ridx;

  rn_reg_if rb ();

  // ********************************
  // helpers
  // ********************************
  function automatic logic [23:0] bus_to_elem(input logic [1:0] rg, input logic [31:0] d);
    // element sits at bus bit 8 up, so a full-word read is 256x the element
    if (rg == 2'h0) begin
      bus_to_elem = d[31:ELEM_LSB];
    end else begin
      bus_to_elem = {d[31:ELEM_LSB+R0_BITS-RX_BITS], 8'h00};
    end
  endfunction : bus_to_elem

  function automatic rn_pkt_t pack_node(input logic [127:0][23:0] mem, input logic [4:0] bn);
    // reg0 24 bits, then reg1..3 16 bits each, standard servo order
    pack_node = {mem[{bn, 2'h0}],
                 mem[{bn, 2'h1}][23:8],
                 mem[{bn, 2'h2}][23:8],
                 mem[{bn, 2'h3}][23:8]};
  endfunction : pack_node

  // ********************************
  // enable word decode
  // ********************************
  assign newer        = st.ctrl[CTRL_NEWER_BIT];
  assign slave        = st.ctrl[CTRL_SLAVE_BIT];
  assign nodes[0]     = newer ? st.a_en[NEW_NODE_LSB +: 16]
                              : st.old_en[OLD_NODE_LSB +: 16];
  assign nodes[1]     = newer ? st.b_en[NEW_NODE_LSB +: 16] : 16'h0000;
  assign sync_node[0] = newer ? st.a_en[NEW_SYNC_LSB +: 4]
                              : st.old_en[OLD_SYNC_LSB +: 4];
  assign sync_node[1] = st.b_en[NEW_SYNC_LSB +: 4];
  assign mnum[0]      = newer ? st.a_en[NEW_MASTER_LSB +: 4]
                              : st.old_en[OLD_MASTER_LSB +: 4];
  assign mnum[1]      = st.b_en[NEW_MASTER_LSB +: 4];

  // ********************************
  // receive match
  // ********************************
  assign rx_node = i_rx_addr[3:0];
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      rx_hit[b] = i_rx_valid && !shutdown && (i_rx_addr[7:4] == mnum[b])
                  && nodes[b][rx_node];
    end
  end
  assign rx_bank = ~rx_hit[0];
  assign rx_sync = (rx_hit[0] && (rx_node == sync_node[0]))
                || (rx_hit[1] && (rx_node == sync_node[1]));
  assign tx_free = ~st.tx_valid | i_tx_ready;

  assign region     = rb.addr[11:8];
  assign ridx       = rb.addr[7:2];
  assign clear_shut = rb.req && rb.wr && (rb.addr == ADDR_STATUS)
                      && rb.wdata[STAT_SHUT_BIT];

  // ********************************
  // next state
  // ********************************
  always_comb begin
    next_st = st;
    if (st.tx_valid && i_tx_ready) begin
      next_st.tx_valid = 1'b0;
    end
    if (|rx_hit) begin
      next_st.in_mem[{rx_bank, rx_node, 2'h0}] = i_rx_data[PKT_BITS-1 -: R0_BITS];
      for (int k = 1; k < 4; k++) begin
        next_st.in_mem[{rx_bank, rx_node, 2'(k)}] =
          {i_rx_data[(3-k)*RX_BITS +: RX_BITS], 8'h00};
      end
    end
    unique case (st.tx_state)
      RN_TX_IDLE: begin
        if (!slave && i_ring_cycle && !shutdown) begin
          next_st.tx_state = RN_TX_SCAN;
          next_st.scan     = 5'h00;
        end
      end
      RN_TX_SCAN: begin
        if (tx_free) begin
          if (nodes[st.scan[4]][st.scan[3:0]]) begin
            next_st.tx_valid = 1'b1;
            next_st.tx_addr  = {mnum[st.scan[4]], st.scan[3:0]};
            next_st.tx_data  = pack_node(st.out_mem, st.scan);
          end
          next_st.scan = st.scan + 5'h01;
          if (st.scan == 5'h1F) begin
            next_st.tx_state = RN_TX_IDLE;
          end
        end
        if (shutdown || slave) begin
          next_st.tx_state = RN_TX_IDLE;
        end
      end
      default: next_st.tx_state = RN_TX_IDLE;
    endcase
    // slave swaps the trapped command for its feedback; a busy port drops it
    if (slave && (|rx_hit) && tx_free) begin
      next_st.tx_valid = 1'b1;
      next_st.tx_addr  = i_rx_addr;
      next_st.tx_data  = pack_node(st.out_mem, {rx_bank, rx_node});
    end
    if (rb.req && rb.wr) begin
      if (region == REGION_SHARED) begin
        next_st.out_mem[{1'b0, ridx}] = bus_to_elem(ridx[1:0], rb.wdata);
      end else if ((region == REGION_A_OUT) || (region == REGION_B_OUT)) begin
        next_st.out_mem[{region[0], ridx}] = bus_to_elem(ridx[1:0], rb.wdata);
      end else begin
        case (rb.addr)
          ADDR_CTRL:     next_st.ctrl     = rb.wdata[1:0];
          ADDR_OLD_EN:   next_st.old_en   = rb.wdata[23:0];
          ADDR_WP_KEY:   next_st.wp_key   = rb.wdata;
          ADDR_WIN_LEN:  next_st.win_len  = rb.wdata[15:0];
          ADDR_ERR_LIM:  next_st.err_lim  = rb.wdata[15:0];
          ADDR_REQ_SYNC: next_st.req_sync = rb.wdata[15:0];
          ADDR_A_EN, ADDR_B_EN: begin
            if (st.wp_key == WP_UNLOCK) begin
              if (rb.addr == ADDR_A_EN) begin
                next_st.a_en = {rb.wdata[31:8], 8'h00};
              end else begin
                next_st.b_en = {rb.wdata[31:8], 8'h00};
              end
            end
            // key is spent by every attempt, good or not
            next_st.wp_key = WP_KEY_RST;
          end
          default: ;
        endcase
      end
    end
  end

  // ********************************
  // register read
  // ********************************
  always_comb begin
    rb.rdata = 32'h00000000;
    if (region == REGION_SHARED) begin
      rb.rdata = {st.in_mem[{1'b0, ridx}], 8'h00};
    end else if ((region == REGION_A_OUT) || (region == REGION_B_OUT)) begin
      rb.rdata = {st.out_mem[{region[0], ridx}], 8'h00};
    end else if ((region == REGION_A_IN) || (region == REGION_B_IN)) begin
      rb.rdata = {st.in_mem[{region[0], ridx}], 8'h00};
    end else begin
      case (rb.addr)
        ADDR_CTRL:     rb.rdata = {30'h00000000, st.ctrl};
        ADDR_OLD_EN:   rb.rdata = {8'h00, st.old_en};
        ADDR_WP_KEY:   rb.rdata = st.wp_key;
        ADDR_A_EN:     rb.rdata = st.a_en;
        ADDR_B_EN:     rb.rdata = st.b_en;
        ADDR_WIN_LEN:  rb.rdata = {16'h0000, st.win_len};
        ADDR_ERR_LIM:  rb.rdata = {16'h0000, st.err_lim};
        ADDR_REQ_SYNC: rb.rdata = {16'h0000, st.req_sync};
        ADDR_STATUS: begin
          rb.rdata[STAT_SHUT_BIT] = shutdown;
          rb.rdata[STAT_ACT_BIT]  = chk_active;
        end
        ADDR_COUNTS:   rb.rdata = {sync_cnt, err_cnt};
        default:       rb.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st          <= '0;
      st.ctrl     <= CTRL_RST;
      st.old_en   <= OLD_EN_RST;
      st.wp_key   <= WP_KEY_RST;
      st.a_en     <= BANK_EN_RST;
      st.b_en     <= BANK_EN_RST;
      st.win_len  <= WIN_LEN_RST;
      st.err_lim  <= ERR_LIM_RST;
      st.req_sync <= REQ_SYNC_RST;
      st.tx_state <= RN_TX_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ********************************
  // submodules and outputs
  // ********************************
  rn_ahb_slave u_ahb (
    .i_sys_clk   (i_sys_clk),
    .i_reset_n   (i_reset_n),
    .i_hsel      (i_hsel),
    .i_haddr     (i_haddr),
    .i_htrans    (i_htrans),
    .i_hwrite    (i_hwrite),
    .i_hsize     (i_hsize),
    .i_hwdata    (i_hwdata),
    .i_hready    (i_hready),
    .o_hreadyout (o_hreadyout),
    .o_hresp     (o_hresp),
    .o_hrdata    (o_hrdata),
    .rb          (rb.bus_side)
  );

  rn_ring_check u_chk (
    .i_sys_clk  (i_sys_clk),
    .i_reset_n  (i_reset_n),
    .i_rti      (i_rti),
    .i_err      (i_rx_err),
    .i_sync     (rx_sync),
    .i_clear    (clear_shut),
    .i_win_len  (st.win_len),
    .i_err_lim  (st.err_lim),
    .i_req_sync (st.req_sync),
    .o_shutdown (shutdown),
    .o_active   (chk_active),
    .o_err_cnt  (err_cnt),
    .o_sync_cnt (sync_cnt)
  );

  assign o_tx_valid      = st.tx_valid & ~shutdown;
  assign o_tx_addr       = st.tx_addr;
  assign o_tx_data       = st.tx_data;
  assign o_ring_shutdown = shutdown;

endmodule : rn_ring_node

// File: rn_pkg.sv
package rn_pkg;

  // ********************************
  // register map (byte addresses)
  // ********************************
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_OLD_EN   = 12'h004;
  localparam logic [11:0] ADDR_WP_KEY   = 12'h008;
  localparam logic [11:0] ADDR_A_EN     = 12'h00C;
  localparam logic [11:0] ADDR_B_EN     = 12'h010;
  localparam logic [11:0] ADDR_WIN_LEN  = 12'h014;
  localparam logic [11:0] ADDR_ERR_LIM  = 12'h018;
  localparam logic [11:0] ADDR_REQ_SYNC = 12'h01C;
  localparam logic [11:0] ADDR_STATUS   = 12'h020;
  localparam logic [11:0] ADDR_COUNTS   = 12'h024;
  // data regions: addr[11:8], element {node, reg} in addr[7:2]
  localparam logic [3:0]  REGION_SHARED = 4'h4;
  localparam logic [3:0]  REGION_A_OUT  = 4'h8;
  localparam logic [3:0]  REGION_B_OUT  = 4'h9;
  localparam logic [3:0]  REGION_A_IN   = 4'hA;
  localparam logic [3:0]  REGION_B_IN   = 4'hB;

  // ********************************
  // fields
  // ********************************
  localparam logic [31:0] WP_UNLOCK      = 32'hAAAAAAAA;
  localparam int          CTRL_SLAVE_BIT = 0;
  localparam int          CTRL_NEWER_BIT = 1;
  localparam int          STAT_SHUT_BIT  = 0;
  localparam int          STAT_ACT_BIT   = 1;
  localparam int          OLD_NODE_LSB   = 0;
  localparam int          OLD_SYNC_LSB   = 16;
  localparam int          OLD_MASTER_LSB = 20;
  localparam int          NEW_NODE_LSB   = 8;
  localparam int          NEW_SYNC_LSB   = 24;
  localparam int          NEW_MASTER_LSB = 28;
  localparam int          ELEM_LSB       = 8;
  localparam int          R0_BITS        = 24;
  localparam int          RX_BITS        = 16;
  localparam int          PKT_BITS       = R0_BITS + 3 * RX_BITS;

  // ********************************
  // reset values
  // ********************************
  localparam logic [1:0]  CTRL_RST     = 2'h0;
  localparam logic [23:0] OLD_EN_RST   = 24'h000000;
  localparam logic [31:0] BANK_EN_RST  = 32'h00000000;
  localparam logic [31:0] WP_KEY_RST   = 32'h00000000;
  localparam logic [15:0] WIN_LEN_RST  = 16'h0000;
  localparam logic [15:0] ERR_LIM_RST  = 16'h0000;
  localparam logic [15:0] REQ_SYNC_RST = 16'h0000;

  typedef enum logic [1:0] {
    RN_TX_IDLE = 2'b01,
    RN_TX_SCAN = 2'b10
  } rn_tx_state_e;

  typedef logic [PKT_BITS-1:0] rn_pkt_t;

endpackage : rn_pkg

// File: rn_reg_if.sv
`timescale 1ns/1ps
interface rn_reg_if;
  logic        req;
  logic        wr;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport bus_side (output req, output wr, output addr, output wdata, input rdata);
  modport core_side (input req, input wr, input addr, input wdata, output rdata);
endinterface : rn_reg_if

// File: rn_ahb_slave.sv
`timescale 1ns/1ps
module rn_ahb_slave (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  rn_reg_if.bus_side       rb
);
  import rn_pkg::*;

  typedef struct packed {
    logic        pend;
    logic        wr;
    logic [11:0] addr;
  } rn_ahb_s;

  rn_ahb_s st;
  rn_ahb_s next_st;

  // ********************************
  // address phase capture
  // ********************************
  // zero wait states: the data phase always completes in one cycle
  always_comb begin
    next_st = st;
    if (i_hready) begin
      next_st.pend = i_hsel & i_htrans[1] & (i_hsize == 3'h2);
      next_st.wr   = i_hwrite;
      next_st.addr = i_haddr[11:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rb.req      = st.pend;
  assign rb.wr       = st.wr;
  assign rb.addr     = st.addr;
  assign rb.wdata    = i_hwdata;
  assign o_hrdata    = rb.rdata;
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

endmodule : rn_ahb_slave

// File: rn_ring_check.sv
`timescale 1ns/1ps
module rn_ring_check (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_rti,
  input  wire logic        i_err,
  input  wire logic        i_sync,
  input  wire logic        i_clear,
  input  wire logic [15:0] i_win_len,
  input  wire logic [15:0] i_err_lim,
  input  wire logic [15:0] i_req_sync,
  output logic             o_shutdown,
  output logic             o_active,
  output logic [15:0]      o_err_cnt,
  output logic [15:0]      o_sync_cnt
);
  import rn_pkg::*;

  typedef struct packed {
    logic [15:0] win;
    logic [15:0] lim;
    logic [15:0] req;
    logic [15:0] rti_cnt;
    logic [15:0] err_cnt;
    logic [15:0] sync_cnt;
    logic        shut;
  } rn_chk_s;

  rn_chk_s     st;
  rn_chk_s     next_st;
  logic [16:0] err_sum;
  logic [16:0] sync_sum;
  logic        last_rti;
  logic        trip;

  // ********************************
  // evaluation window
  // ********************************
  always_comb begin
    next_st  = st;
    err_sum  = {1'b0, st.err_cnt} + {16'h0000, i_err};
    sync_sum = {1'b0, st.sync_cnt} + {16'h0000, i_sync};
    last_rti = i_rti && (st.rti_cnt == st.win - 16'h0001);
    trip     = 1'b0;
    if (st.win == 16'h0000) begin
      // checking off: new settings are taken at once
      next_st.win      = i_win_len;
      next_st.lim      = i_err_lim;
      next_st.req      = i_req_sync;
      next_st.rti_cnt  = 16'h0000;
      next_st.err_cnt  = 16'h0000;
      next_st.sync_cnt = 16'h0000;
    end else begin
      next_st.err_cnt  = err_sum[16] ? 16'hFFFF : err_sum[15:0];
      next_st.sync_cnt = sync_sum[16] ? 16'hFFFF : sync_sum[15:0];
      if (i_err && (err_sum > {1'b0, st.lim})) begin
        trip = 1'b1;
      end
      if (i_rti) begin
        next_st.rti_cnt = st.rti_cnt + 16'h0001;
      end
      if (last_rti) begin
        if (sync_sum < {1'b0, st.req}) begin
          trip = 1'b1;
        end
        next_st.win      = i_win_len;
        next_st.lim      = i_err_lim;
        next_st.req      = i_req_sync;
        next_st.rti_cnt  = 16'h0000;
        next_st.err_cnt  = 16'h0000;
        next_st.sync_cnt = 16'h0000;
      end
    end
    // a trip in the clearing cycle still sets the flag
    next_st.shut = trip | (st.shut & ~i_clear);
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_shutdown = st.shut;
  assign o_active   = (st.win != 16'h0000);
  assign o_err_cnt  = st.err_cnt;
  assign o_sync_cnt = st.sync_cnt;

endmodule : rn_ring_check

// File: rn_ring_node_properties.sv
`timescale 1ns/1ps
module rn_ring_node_checker (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic        i_rti,
  input  wire logic        i_rx_err,
  input  wire logic        i_tx_ready,
  input  wire logic        o_hreadyout,
  input  wire logic        o_hresp,
  input  wire logic [31:0] o_hrdata,
  input  wire logic        o_tx_valid,
  input  wire logic [7:0]  o_tx_addr,
  input  wire logic        o_ring_shutdown
);
  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  logic rd;
  assign rd = i_hsel && i_htrans[1] && !i_hwrite;

  zero_wait_a: assert property (o_hreadyout && !o_hresp)
    else $error("bus slave stalled or answered an error");
  shut_sticky_a: assert property (o_ring_shutdown && !i_hsel |=> o_ring_shutdown)
    else $error("shutdown cleared without software");
  shut_quiet_a: assert property (o_ring_shutdown |-> !o_tx_valid)
    else $error("packet offered during shutdown");
  tx_hold_a: assert property (
    o_tx_valid && !i_tx_ready |=> o_ring_shutdown || (o_tx_valid && $stable(o_tx_addr)))
    else $error("packet withdrawn before taken");
  shut_cause_a: assert property (
    !o_ring_shutdown && !i_rx_err && !i_rti |=> !o_ring_shutdown)
    else $error("shutdown without error or window tick");
  elem_low_a: assert property (rd && i_haddr[11:10] == 2'b10 |=> o_hrdata[7:0] == 8'h00)
    else $error("bank element low byte not zero");
  reg_low_a: assert property (
    rd && i_haddr[11:10] == 2'b10 && i_haddr[3:2] != 2'h0 |=> o_hrdata[15:0] == 16'h0000)
    else $error("bank short element low half not zero");
  shared_low_a: assert property (rd && i_haddr[11:8] == 4'h4 |=> o_hrdata[7:0] == 8'h00)
    else $error("shared element low byte not zero");

  cover property ($rose(o_ring_shutdown));
  cover property (o_tx_valid && i_tx_ready);
  cover property (rd ##1 o_hrdata != 32'h0);
endmodule : rn_ring_node_checker

// File: rn_ring_partner.sv
`timescale 1ns/1ps
module rn_ring_partner (
  input  wire logic            i_sys_clk,
  input  wire logic            i_tx_valid,
  input  wire logic [7:0]      i_tx_addr,
  input  wire rn_pkg::rn_pkt_t i_tx_data,
  output logic                 o_rx_valid,
  output logic [7:0]           o_rx_addr,
  output rn_pkg::rn_pkt_t      o_rx_data,
  output logic                 o_tx_ready
);
  import rn_pkg::*;
  // slow far side: refuses one cycle more than this before taking a packet
  int         stall = 0;
  int         wait_n = 0;
  logic [7:0] got_addr[$];
  rn_pkt_t    got_data[$];
  initial begin
    o_rx_valid = 1'b0;
    o_rx_addr = 8'h00;
    o_rx_data = '0;
    o_tx_ready = 1'b0;
  end
  always @(posedge i_sys_clk) begin
    if (i_tx_valid && o_tx_ready) begin
      got_addr.push_back(i_tx_addr);
      got_data.push_back(i_tx_data);
    end
    wait_n <= (i_tx_valid && !o_tx_ready) ? wait_n + 1 : 0;
    o_tx_ready <= i_tx_valid && !o_tx_ready && wait_n >= stall;
  end
  // one packet, {master, node}; released lines show the inverse
  task automatic send(input logic [7:0] a, input rn_pkt_t d);
    @(posedge i_sys_clk);
    o_rx_valid <= 1'b1;
    o_rx_addr <= a;
    o_rx_data <= d;
    @(posedge i_sys_clk);
    o_rx_valid <= 1'b0;
    o_rx_addr <= ~a;
    o_rx_data <= ~d;
  endtask : send
endmodule : rn_ring_partner

// File: rn_ring_node_bench.sv
`timescale 1ns/1ps
module rn_ring_node_bench;
  import rn_pkg::*;
  logic        i_sys_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0]  ev = 3'h0;
  logic        hready, hresp, txv, txr, rxv, shut;
  logic [31:0] hrdata;
  logic [7:0]  txa, rxa;
  rn_pkt_t     txd, rxd;
  int          err_count = 0;
  int          comparisons = 0;

  always #2.5 i_sys_clk = ~i_sys_clk;

  rn_ring_node rn_ring_node_inst (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
    .i_ring_cycle(ev[0]), .i_rti(ev[1]), .i_rx_valid(rxv), .i_rx_addr(rxa),
    .i_rx_data(rxd), .i_rx_err(ev[2]), .o_tx_valid(txv), .i_tx_ready(txr),
    .o_tx_addr(txa), .o_tx_data(txd), .o_ring_shutdown(shut));
  rn_ring_partner rn_ring_partner_inst (
    .i_sys_clk(i_sys_clk), .i_tx_valid(txv), .i_tx_addr(txa), .i_tx_data(txd),
    .o_rx_valid(rxv), .o_rx_addr(rxa), .o_rx_data(rxd), .o_tx_ready(txr));

  // ********************************
  // bus and check tasks
  // ********************************
  task automatic cmp(input string n, input logic [79:0] e, input logic [79:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic phase(output logic [31:0] r);
    logic ok;
    // answer and read data are taken at the edge that ends the phase
    do begin
      @(posedge i_sys_clk);
      ok = hready;
      r = hrdata;
    end while (ok !== 1'b1);
  endtask : phase
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge i_sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    phase(r);
    htrans <= 2'h0;
    hwdata <= d;
    phase(r);
    hsel <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask : wr
  task automatic chk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(a, 1'b0, 32'h0, r);
    cmp($sformatf("register %h", a), 80'(e), 80'(r));
  endtask : chk
  task automatic pulse(input logic [2:0] m);
    @(posedge i_sys_clk);
    ev <= m;
    @(posedge i_sys_clk);
    ev <= 3'h0;
  endtask : pulse
  task automatic wait_pkts(input int n);
    for (int k = 0; k < 300 && rn_ring_partner_inst.got_addr.size() < n; k++)
      @(posedge i_sys_clk);
  endtask : wait_pkts
  task automatic chk_pkt(input logic [7:0] a, input rn_pkt_t d);
    cmp("packet count", 80'(1), 80'(rn_ring_partner_inst.got_addr.size()));
    cmp("packet address", 80'(a), 80'(rn_ring_partner_inst.got_addr[0]));
    cmp("packet data", 80'(d), 80'(rn_ring_partner_inst.got_data[0]));
  endtask : chk_pkt
  function automatic logic [11:0] el(input logic [3:0] g, input logic [3:0] n,
                                     input logic [1:0] k);
    return {g, n, k, 2'b00};
  endfunction : el
  task automatic complete_run;
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  // ********************************
  // tests
  // ********************************
  initial begin
    repeat (20) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    for (int i = 0; i < 11; i++) chk(12'(i * 4), 32'h0);
    chk(12'h300, 32'h0);
    wr(ADDR_CTRL, 32'h2);
    wr(ADDR_A_EN, 32'h1F0001FF);
    chk(ADDR_A_EN, 32'h0);
    wr(ADDR_WP_KEY, WP_UNLOCK);
    wr(ADDR_A_EN, 32'h1F0001FF);
    chk(ADDR_A_EN, 32'h1F000100);
    wr(ADDR_A_EN, 32'h0);
    chk(ADDR_A_EN, 32'h1F000100);
    wr(el(REGION_A_OUT, 4'h0, 2'h0), 32'h123456FF);
    wr(el(REGION_A_OUT, 4'h0, 2'h1), 32'hABCDEFFF);
    chk(el(REGION_A_OUT, 4'h0, 2'h0), 32'h12345600);
    chk(el(REGION_A_OUT, 4'h0, 2'h1), 32'hABCD0000);
    rn_ring_partner_inst.stall = 3;
    pulse(3'h1);
    wait_pkts(1);
    chk_pkt(8'h10, {24'h123456, 16'hABCD, 32'h0});
    rn_ring_partner_inst.send(8'h10, {24'hC0FFEE, 16'h1111, 16'h2222, 16'h3333});
    chk(el(REGION_A_IN, 4'h0, 2'h0), 32'hC0FFEE00);
    chk(el(REGION_A_IN, 4'h0, 2'h3), 32'h33330000);
    chk(el(REGION_B_IN, 4'h0, 2'h0), 32'h0);
    // older word governs, slave of master 2, node 2 only
    rn_ring_partner_inst.got_addr.delete();
    rn_ring_partner_inst.got_data.delete();
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_OLD_EN, 32'h002F0004);
    chk(ADDR_OLD_EN, 32'h002F0004);
    wr(el(REGION_SHARED, 4'h2, 2'h0), 32'h55AA33FF);
    chk(el(REGION_SHARED, 4'h2, 2'h0), 32'h0);
    chk(el(REGION_A_OUT, 4'h2, 2'h0), 32'h55AA3300);
    rn_ring_partner_inst.send(8'h22, {24'h00ABCD, 16'h4321, 32'h0});
    wait_pkts(1);
    chk_pkt(8'h22, {24'h55AA33, 48'h0});
    chk(el(REGION_SHARED, 4'h2, 2'h0), 32'h00ABCD00);
    chk(el(REGION_SHARED, 4'h2, 2'h1), 32'h43210000);
    rn_ring_partner_inst.send(8'h12, {24'h777777, 48'h0});
    repeat (40) @(posedge i_sys_clk);
    chk_pkt(8'h22, {24'h55AA33, 48'h0});
    // ring check: length 0 ignores errors
    repeat (3) pulse(3'h4);
    chk(ADDR_STATUS, 32'h0);
    wr(ADDR_ERR_LIM, 32'h2);
    wr(ADDR_REQ_SYNC, 32'h2);
    wr(ADDR_WIN_LEN, 32'h4);
    repeat (2) pulse(3'h4);
    chk(ADDR_STATUS, 32'h2);
    pulse(3'h4);
    chk(ADDR_STATUS, 32'h3);
    cmp("shutdown flag", 80'(1'b1), 80'(shut));
    wr(ADDR_STATUS, 32'h1);
    chk(ADDR_STATUS, 32'h2);
    repeat (3) pulse(3'h2);
    chk(ADDR_STATUS, 32'h2);
    pulse(3'h2);
    chk(ADDR_STATUS, 32'h3);
    chk(ADDR_COUNTS, 32'h0);
    complete_run();
  end

  // whole run needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    err_count++;
    complete_run();
  end
endmodule : rn_ring_node_bench

bind rn_ring_node rn_ring_node_checker rn_ring_node_checker_inst (
  .i_sys_clk, .i_reset_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_rti, .i_rx_err,
  .i_tx_ready, .o_hreadyout, .o_hresp, .o_hrdata, .o_tx_valid, .o_tx_addr,
  .o_ring_shutdown);
